// *** rtl/ec_memory_map_regs.vh ***
// Address map, register offsets, field positions and bus codes
// for the controller memory glue. Included by the design file only.
`ifndef EC_MEMORY_MAP_REGS_VH
`define EC_MEMORY_MAP_REGS_VH

// ----------------------------------------
// Controller address map (24-bit space)
// ----------------------------------------
`define ROM_BASE 24'h00_0000
`define ROM_LAST 24'h01_FFFF
`define ROM_WORDS 15'h6000
`define ALIAS_BASE 24'h06_0000
`define ALIAS_LAST 24'h06_3FFF
`define FETCH_SAFE_LAST 24'h7F_FFFF
`define DTM_BASE 24'h80_0000
`define DTM_LAST 24'h80_3FFF
`define REG_BASE 24'hF0_FC00

// ----------------------------------------
// Register offsets, fields and reset values
// ----------------------------------------
`define SRAM_CONFIG_OFS 24'h00_0000
`define BUS_ERROR_ADDRESS_OFS 24'h00_0004
`define RAM_SELECT_BIT 0
`define SRAM_CONFIG_RST 32'h0000_0000
`define RAM_SELECT_RST 1'b0
`define BUS_ERROR_ADDRESS_RST 24'h00_0000

// ----------------------------------------
// Memory geometry and fill values
// ----------------------------------------
`define DTM_INDEX_W 12
`define ROM_INDEX_W 15
`define EMPTY_WORD 32'hFFFF_FFFF

// ----------------------------------------
// Access sizes and AHB codes
// ----------------------------------------
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define HTRANS_IDLE 2'h0
`define HTRANS_NONSEQ 2'h2
`define HBURST_SINGLE 3'h0

`endif

// *** rtl/ec_memory_map_bus_fault.v ***
// Memory glue of the embedded controller: tightly coupled data SRAM with
// an optional instruction alias, instruction ROM port, fetch decode, the
// single AHB master and the bus fault address capture.
// Assumes a synchronous-read ROM macro outside, AHB slaves on the same clock,
// and core write data already placed on its byte lanes.
`timescale 1ns/10ps
`include "ec_memory_map_regs.vh"

module ec_memory_map_bus_fault
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Instruction fetch port
  input wire i_fetch_req,
  input wire [23:0] i_fetch_addr,
  output wire o_fetch_ready,
  output wire o_fetch_valid,
  output reg [31:0] o_fetch_data,
  // Data load/store port
  input wire i_data_req,
  input wire i_data_we,
  input wire [1:0] i_data_size,
  input wire [23:0] i_data_addr,
  input wire [31:0] i_data_wdata,
  output wire o_data_ready,
  output wire o_data_valid,
  output reg [31:0] o_data_rdata,
  output wire o_mem_error,
  // Instruction ROM macro
  output wire o_rom_en,
  output wire [14:0] o_rom_addr,
  input wire [31:0] i_rom_data,
  // AHB master
  output wire [31:0] o_haddr,
  output wire [1:0] o_htrans,
  output wire o_hwrite,
  output wire [2:0] o_hsize,
  output wire [2:0] o_hburst,
  output wire [31:0] o_hwdata,
  input wire [31:0] i_hrdata,
  input wire i_hready,
  input wire i_hresp
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam A_IDLE = 2'd0;
  localparam A_ADDR = 2'd1;
  localparam A_DATA = 2'd2;
  localparam SRC_SRAM = 2'd0;
  localparam SRC_REG = 2'd1;
  localparam SRC_ROM = 2'd2;
  localparam SRC_AHB = 2'd3;
  localparam F_ROM = 2'd0;
  localparam F_SRAM = 2'd1;
  localparam F_EMPTY = 2'd2;
  localparam F_AHB = 2'd3;

  reg [31:0] sram_mem [0:4095];
  reg [31:0] sram_data_q;
  reg [31:0] sram_fetch_q;
  reg ram_select_reg;
  reg [23:0] fault_addr_reg;
  reg capture_armed_reg;
  reg [1:0] a_state_reg;
  reg [23:0] ahb_addr_reg;
  reg ahb_write_reg;
  reg [1:0] ahb_size_reg;
  reg [31:0] ahb_wdata_reg;
  reg ahb_fetch_reg;
  reg d_valid_reg;
  reg [1:0] d_src_reg;
  reg [31:0] d_rdata_reg;
  reg rom_phase_reg;
  reg [14:0] rom_data_index_reg;
  reg rom_data_empty_reg;
  reg f_valid_reg;
  reg [1:0] f_src_reg;
  reg [31:0] f_rdata_reg;
  reg mem_error_reg;
  reg [3:0] byte_en;

  wire d_dtm;
  wire d_rom;
  wire d_cfg;
  wire d_err;
  wire d_ahb;
  wire d_take;
  wire f_rom;
  wire f_alias;
  wire f_safe;
  wire f_ahb;
  wire f_take;
  wire ahb_done;
  wire ahb_err;
  wire [11:0] d_index;
  wire [11:0] f_index;
  wire [14:0] f_rom_index;
  wire [14:0] d_rom_index;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Data side: SRAM window, ROM, local registers, everything else on AHB
  assign d_dtm = (i_data_addr >= `DTM_BASE) && (i_data_addr <= `DTM_LAST);
  assign d_rom = (i_data_addr <= `ROM_LAST);
  assign d_cfg = (i_data_addr[23:2] == (`REG_BASE + `SRAM_CONFIG_OFS) >> 2);
  assign d_err = (i_data_addr[23:2] == (`REG_BASE + `BUS_ERROR_ADDRESS_OFS) >> 2);
  assign d_ahb = !d_dtm && !d_rom && !d_cfg && !d_err;
  assign d_index = i_data_addr[13:2];
  assign d_rom_index = i_data_addr[16:2];

  // Fetch side: the data window is not decoded here, so such fetches lie
  // above the safe limit and go out on the AHB instead of reaching the SRAM
  assign f_rom = (i_fetch_addr <= `ROM_LAST);
  assign f_alias = ram_select_reg && (i_fetch_addr >= `ALIAS_BASE) &&
                   (i_fetch_addr <= `ALIAS_LAST);
  assign f_safe = (i_fetch_addr <= `FETCH_SAFE_LAST);
  assign f_ahb = !f_safe;
  assign f_index = i_fetch_addr[13:2];
  assign f_rom_index = i_fetch_addr[16:2];

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  // Data waits while the ROM is busy with it or the AHB is occupied
  assign o_data_ready = !rom_phase_reg && (a_state_reg == A_IDLE);
  assign d_take = i_data_req && o_data_ready;
  // The ROM has one port, so a fetch yields for the data ROM cycle; fetches
  // to the AHB also wait for a free bus, data having priority
  assign o_fetch_ready = !rom_phase_reg && !(a_state_reg != A_IDLE && ahb_fetch_reg) &&
                         !(f_ahb && (a_state_reg != A_IDLE || (d_take && d_ahb)));
  assign f_take = i_fetch_req && o_fetch_ready;

  // ----------------------------------------
  // Byte enables for SRAM stores
  // ----------------------------------------
  always @*
  begin
    case (i_data_size)
      `SIZE_BYTE: byte_en = 4'h1 << i_data_addr[1:0];
      `SIZE_HALF: byte_en = i_data_addr[1] ? 4'hC : 4'h3;
      default: byte_en = 4'hF;
    endcase
  end

  // ----------------------------------------
  // Dual-port SRAM
  // ----------------------------------------
  // Port A serves data, port B alias fetches, both in the same cycle
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : g_lane
      always @(posedge i_clk)
      begin
        if (d_take && d_dtm && i_data_we && byte_en[lane])
        begin
          sram_mem[d_index][lane*8 +: 8] <= i_data_wdata[lane*8 +: 8];
        end
      end
    end
  endgenerate

  // Read ports are plain registered reads, no reset needed on data
  always @(posedge i_clk)
  begin
    if (d_take && d_dtm)
    begin
      sram_data_q <= sram_mem[d_index];
    end
    if (f_take && f_alias)
    begin
      sram_fetch_q <= sram_mem[f_index];
    end
  end

  // ----------------------------------------
  // ROM port
  // ----------------------------------------
  // Data ROM accesses take the port one cycle after acceptance
  assign o_rom_en = rom_phase_reg || (f_take && f_rom);
  assign o_rom_addr = rom_phase_reg ? rom_data_index_reg : f_rom_index;

  // ----------------------------------------
  // Data side completion
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      d_valid_reg <= 1'b0;
      d_src_reg <= SRC_SRAM;
      d_rdata_reg <= 32'h0000_0000;
      rom_phase_reg <= 1'b0;
      rom_data_index_reg <= 15'h0000;
      rom_data_empty_reg <= 1'b0;
    end
    else
    begin
      d_valid_reg <= 1'b0;
      rom_phase_reg <= 1'b0;
      if (rom_phase_reg)
      begin
        d_valid_reg <= 1'b1;
        d_src_reg <= SRC_ROM;
      end
      else if (d_take && d_rom)
      begin
        rom_phase_reg <= 1'b1;
        rom_data_index_reg <= d_rom_index;
        rom_data_empty_reg <= (d_rom_index >= `ROM_WORDS);
      end
      else if (d_take && d_dtm)
      begin
        d_valid_reg <= 1'b1;
        d_src_reg <= SRC_SRAM;
      end
      else if (d_take && (d_cfg || d_err))
      begin
        d_valid_reg <= 1'b1;
        d_src_reg <= SRC_REG;
        d_rdata_reg <= d_cfg ? {31'h0000_0000, ram_select_reg} : {8'h00, fault_addr_reg};
      end
      else if (ahb_done && !ahb_fetch_reg)
      begin
        d_valid_reg <= 1'b1;
        d_src_reg <= SRC_AHB;
        d_rdata_reg <= i_hrdata;
      end
    end
  end

  // Read data lanes are returned whole; the core picks its bytes
  always @*
  begin
    case (d_src_reg)
      SRC_SRAM: o_data_rdata = sram_data_q;
      SRC_ROM: o_data_rdata = rom_data_empty_reg ? `EMPTY_WORD : i_rom_data;
      default: o_data_rdata = d_rdata_reg;
    endcase
  end
  assign o_data_valid = d_valid_reg;

  // ----------------------------------------
  // Fetch side completion
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      f_valid_reg <= 1'b0;
      f_src_reg <= F_EMPTY;
      f_rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      f_valid_reg <= 1'b0;
      if (ahb_done && ahb_fetch_reg)
      begin
        f_valid_reg <= 1'b1;
        f_src_reg <= F_AHB;
        f_rdata_reg <= i_hrdata;
      end
      else if (f_take && !f_ahb)
      begin
        f_valid_reg <= 1'b1;
        if (f_rom && (f_rom_index < `ROM_WORDS))
        begin
          f_src_reg <= F_ROM;
        end
        else if (f_alias)
        begin
          f_src_reg <= F_SRAM;
        end
        else
        begin
          f_src_reg <= F_EMPTY;
        end
      end
    end
  end

  // Holes below the safe limit answer all ones and never fault
  always @*
  begin
    case (f_src_reg)
      F_ROM: o_fetch_data = i_rom_data;
      F_SRAM: o_fetch_data = sram_fetch_q;
      F_EMPTY: o_fetch_data = `EMPTY_WORD;
      default: o_fetch_data = f_rdata_reg;
    endcase
  end
  assign o_fetch_valid = f_valid_reg;

  // ----------------------------------------
  // AHB master
  // ----------------------------------------
  // One single transfer at a time: address phase, then data phase
  assign ahb_done = (a_state_reg == A_DATA) && i_hready;
  assign ahb_err = ahb_done && i_hresp;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      a_state_reg <= A_IDLE;
      ahb_addr_reg <= 24'h00_0000;
      ahb_write_reg <= 1'b0;
      ahb_size_reg <= `SIZE_WORD;
      ahb_wdata_reg <= 32'h0000_0000;
      ahb_fetch_reg <= 1'b0;
    end
    else
    begin
      case (a_state_reg)
        A_IDLE:
        begin
          if (d_take && d_ahb)
          begin
            a_state_reg <= A_ADDR;
            ahb_addr_reg <= i_data_addr;
            ahb_write_reg <= i_data_we;
            ahb_size_reg <= i_data_size;
            ahb_wdata_reg <= i_data_wdata;
            ahb_fetch_reg <= 1'b0;
          end
          else if (f_take && f_ahb)
          begin
            a_state_reg <= A_ADDR;
            ahb_addr_reg <= {i_fetch_addr[23:2], 2'b00};
            ahb_write_reg <= 1'b0;
            ahb_size_reg <= `SIZE_WORD;
            ahb_fetch_reg <= 1'b1;
          end
        end
        A_ADDR:
        begin
          if (i_hready)
          begin
            a_state_reg <= A_DATA;
          end
        end
        A_DATA:
        begin
          if (i_hready)
          begin
            a_state_reg <= A_IDLE;
          end
        end
        default: a_state_reg <= A_IDLE;
      endcase
    end
  end

  assign o_haddr = {8'h00, ahb_addr_reg};
  assign o_htrans = (a_state_reg == A_ADDR) ? `HTRANS_NONSEQ : `HTRANS_IDLE;
  assign o_hwrite = ahb_write_reg;
  assign o_hsize = {1'b0, ahb_size_reg};
  assign o_hburst = `HBURST_SINGLE;
  assign o_hwdata = ahb_wdata_reg;

  // ----------------------------------------
  // Registers and fault capture
  // ----------------------------------------
  // A fault arriving with a re-arming write is still captured, so no
  // error is lost to the write
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ram_select_reg <= `RAM_SELECT_RST;
      fault_addr_reg <= `BUS_ERROR_ADDRESS_RST;
      capture_armed_reg <= 1'b1;
      mem_error_reg <= 1'b0;
    end
    else
    begin
      mem_error_reg <= ahb_err;
      if (d_take && d_cfg && i_data_we && byte_en[0])
      begin
        ram_select_reg <= i_data_wdata[`RAM_SELECT_BIT];
      end
      if (ahb_err && (capture_armed_reg || (d_take && d_err && i_data_we)))
      begin
        fault_addr_reg <= ahb_addr_reg;
        capture_armed_reg <= 1'b0;
      end
      else if (d_take && d_err && i_data_we)
      begin
        fault_addr_reg <= `BUS_ERROR_ADDRESS_RST;
        capture_armed_reg <= 1'b1;
      end
    end
  end
  assign o_mem_error = mem_error_reg;

endmodule // ec_memory_map_bus_fault

// *** test/ec_far_side_model.sv ***
// Far side of the memory glue: instruction ROM macro and one AHB slave.
// Assumes one clock; AHB addresses with bits 23:20 equal to Eh answer with ERROR.
`timescale 1ns/10ps
module ec_far_side_model
(
  // Clock, reset and bench control
  input wire i_clk,
  input wire i_rst,
  input wire [1:0] i_wait,
  // ROM macro
  input wire i_rom_en,
  input wire [14:0] i_rom_addr,
  output reg [31:0] o_rom_data,
  // AHB slave
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [31:0] i_hwdata,
  output wire [31:0] o_hrdata,
  output wire o_hready,
  output wire o_hresp
);
  reg [31:0] mem_reg [0:15];
  reg act_reg, wr_reg, err_reg, ph_reg;
  reg [1:0] cnt_reg;
  reg [3:0] idx_reg;
  reg [31:0] junk_reg;
  wire last = act_reg & (cnt_reg == 2'h0);
  // Read data only in the closing cycle; a toggling pattern otherwise
  assign o_hready = ~act_reg | (last & (~err_reg | ph_reg));
  assign o_hresp = last & err_reg;
  assign o_hrdata = (last & ~wr_reg) ? mem_reg[idx_reg] : junk_reg;
  // Synchronous ROM; the word carries its index, idle output keeps changing
  always @(posedge i_clk)
    o_rom_data <= i_rom_en ? {17'h1_0000, i_rom_addr} : ~o_rom_data;
  // Slave state: wait states, then a two-cycle error or a plain finish
  always @(posedge i_clk or posedge i_rst)
    if (i_rst)
    begin
      act_reg <= 1'b0;
      junk_reg <= 32'h0000_0000;
    end
    else
    begin
      junk_reg <= ~junk_reg;
      if (!act_reg)
      begin
        if (i_htrans == 2'h2)
        begin
          act_reg <= 1'b1;
          wr_reg <= i_hwrite;
          idx_reg <= i_haddr[5:2];
          err_reg <= (i_haddr[23:20] == 4'hE);
          cnt_reg <= i_wait;
          ph_reg <= 1'b0;
        end
      end
      else if (cnt_reg != 2'h0)
        cnt_reg <= cnt_reg - 2'h1;
      else if (err_reg & ~ph_reg)
        ph_reg <= 1'b1;
      else
      begin
        act_reg <= 1'b0;
        if (wr_reg)
          mem_reg[idx_reg] <= i_hwdata;
      end
    end
endmodule // ec_far_side_model

// *** test/ec_glue_props.sv ***
// Port checker for the memory glue.
// Assumes it is bound into ec_memory_map_bus_fault.
`timescale 1ns/10ps
module ec_glue_props
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Core ports
  input wire i_fetch_req,
  input wire [23:0] i_fetch_addr,
  input wire o_fetch_ready,
  input wire o_fetch_valid,
  input wire i_data_req,
  input wire i_data_we,
  input wire [1:0] i_data_size,
  input wire [23:0] i_data_addr,
  input wire o_data_ready,
  input wire o_data_valid,
  input wire o_mem_error,
  // AHB
  input wire [31:0] o_haddr,
  input wire [1:0] o_htrans,
  input wire o_hwrite,
  input wire [2:0] o_hsize,
  input wire [2:0] o_hburst,
  input wire i_hready,
  input wire i_hresp
);
  // ----
  // Helpers
  // ----
  wire f_go = i_fetch_req & o_fetch_ready;
  wire d_go = i_data_req & o_data_ready;
  wire d_ram = d_go & (i_data_addr[23:14] == 10'h200);
  // Data requests for the AHB: not ROM, SRAM or local registers
  wire d_ahb = d_go & (i_data_addr > 24'h01_FFFF) & ~d_ram & (i_data_addr[23:3] != 21'h1E_1F80);
  reg dphase_reg;
  // Tracks the AHB data phase so an error is tied to its transfer
  always @(posedge i_clk or posedge i_rst)
    if (i_rst)
      dphase_reg <= 1'b0;
    else if (i_hready)
      dphase_reg <= (o_htrans == 2'h2);
  wire err_end = dphase_reg & i_hready & i_hresp;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sram_lat_a: assert property (d_ram |=> o_data_valid)
    else $error("sram access late");
  sram_free_a: assert property (d_ram && !(f_go && i_fetch_addr[23]) |=> o_data_ready && o_fetch_ready)
    else $error("sram access stalled");
  rom_data_a: assert property (d_go && i_data_addr <= 24'h01_FFFF |=> !o_data_valid && !o_data_ready ##1 o_data_valid)
    else $error("rom data timing wrong");
  fetch_lat_a: assert property (f_go && i_fetch_addr <= 24'h7F_FFFF |=> o_fetch_valid)
    else $error("low fetch late");
  one_xfer_a: assert property (o_htrans == 2'h2 |=> o_htrans == 2'h0)
    else $error("second transfer issued");
  fetch_word_a: assert property (f_go && i_fetch_addr[23] |=> o_htrans == 2'h2 && !o_hwrite &&
    o_hsize == 3'h2 && o_haddr[23:2] == $past(i_fetch_addr[23:2]))
    else $error("fetch not a word read");
  store_size_a: assert property (d_ahb |=> o_htrans == 2'h2 && o_hwrite == $past(i_data_we) &&
    o_hsize == {1'b0, $past(i_data_size)} && o_hburst == 3'h0)
    else $error("data transfer size wrong");
  mem_err_a: assert property (o_mem_error == $past(err_end))
    else $error("memory error pulse wrong");
endmodule // ec_glue_props

bind ec_memory_map_bus_fault ec_glue_props props_i (.i_clk, .i_rst, .i_fetch_req, .i_fetch_addr,
  .o_fetch_ready, .o_fetch_valid, .i_data_req, .i_data_we, .i_data_size, .i_data_addr, .o_data_ready,
  .o_data_valid, .o_mem_error, .o_haddr, .o_htrans, .o_hwrite, .o_hsize, .o_hburst, .i_hready, .i_hresp);

// *** test/tb.sv ***
// Self-checking bench for the memory glue.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/10ps
module tb;
  reg i_clk, i_rst, f_req, d_req, d_we;
  reg [1:0] d_size, wait_cnt;
  reg [23:0] f_addr, d_addr;
  reg [31:0] d_wdata, got;
  wire f_rdy, f_val, d_rdy, d_val, m_err, rom_en, hwr, hrdy, hrsp;
  wire [31:0] f_data, d_rdata, rom_q, haddr, hwdata, hrdata;
  wire [14:0] rom_a;
  wire [1:0] htrans;
  wire [2:0] hsize, hburst;
  integer mismatches, checked;
  ec_memory_map_bus_fault dut (.i_clk(i_clk), .i_rst(i_rst), .i_fetch_req(f_req), .i_fetch_addr(f_addr),
    .o_fetch_ready(f_rdy), .o_fetch_valid(f_val), .o_fetch_data(f_data), .i_data_req(d_req), .i_data_we(d_we),
    .i_data_size(d_size), .i_data_addr(d_addr), .i_data_wdata(d_wdata), .o_data_ready(d_rdy),
    .o_data_valid(d_val), .o_data_rdata(d_rdata), .o_mem_error(m_err), .o_rom_en(rom_en), .o_rom_addr(rom_a),
    .i_rom_data(rom_q), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwr), .o_hsize(hsize),
    .o_hburst(hburst), .o_hwdata(hwdata), .i_hrdata(hrdata), .i_hready(hrdy), .i_hresp(hrsp));
  ec_far_side_model far (.i_clk(i_clk), .i_rst(i_rst), .i_wait(wait_cnt), .i_rom_en(rom_en),
    .i_rom_addr(rom_a), .o_rom_data(rom_q), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwr),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hready(hrdy), .o_hresp(hrsp));
  // ----
  // Clock and shared tasks
  // ----
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task give_verdict;
  begin
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got_v, input [31:0] exp_v);
  begin
    checked = checked + 1;
    if (got_v !== exp_v)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t got %h exp %h", $time, got_v, exp_v);
    end
  end
  endtask
  // Bounded wait at the falling edge, where combinational flags have settled
  task await(input [1:0] sel);
    integer n;
  begin
    n = 0;
    @(negedge i_clk);
    while ((sel == 2'h0 ? d_rdy : sel == 2'h1 ? d_val : sel == 2'h2 ? f_rdy : f_val) !== 1'b1)
    begin
      n = n + 1;
      if (n > 40)
      begin
        mismatches = mismatches + 1;
        give_verdict;
      end
      @(negedge i_clk);
    end
  end
  endtask
  // Kind 0 load, 1 store, 2 fetch; request held until the accepting edge
  task op(input [1:0] kind, input [1:0] sz, input [23:0] a, input [31:0] wd);
  begin
    @(posedge i_clk);
    f_req <= kind[1];
    f_addr <= a;
    d_req <= ~kind[1];
    d_we <= kind[0];
    d_size <= sz;
    d_addr <= a;
    d_wdata <= wd;
    await({kind[1], 1'b0});
    @(posedge i_clk);
    f_req <= 1'b0;
    d_req <= 1'b0;
    await({kind[1], 1'b1});
    got = kind[1] ? f_data : d_rdata;
  end
  endtask
  // ----
  // Scenarios
  // ----
  task t_sram;
  begin
    op(0, 2, 24'hF0_FC00, 0);
    chk(got, 32'h0000_0000);
    op(0, 2, 24'hF0_FC04, 0);
    chk(got, 32'h0000_0000);
    op(1, 2, 24'h80_3FFC, 32'h1122_3344);
    op(1, 0, 24'h80_3FFD, 32'h0000_AB00);
    op(0, 2, 24'h80_3FFC, 0);
    chk(got, 32'h1122_AB44);
    op(1, 2, 24'h80_0010, 32'h1234_5678);
  end
  endtask
  task t_rom;
  begin
    op(2, 2, 24'h01_7FFC, 0);
    chk(got, 32'h8000_5FFF);
    op(2, 2, 24'h01_8000, 0);
    chk(got, 32'hFFFF_FFFF);
    op(2, 2, 24'h7F_FFFC, 0);
    chk(got, 32'hFFFF_FFFF);
    op(0, 2, 24'h00_0010, 0);
    chk(got, 32'h8000_0004);
  end
  endtask
  // Alias closed, then opened with a fetch and a load in the same cycle
  task t_alias;
  begin
    op(2, 2, 24'h06_0010, 0);
    chk(got, 32'hFFFF_FFFF);
    op(1, 2, 24'hF0_FC00, 32'h0000_0001);
    @(posedge i_clk);
    f_req <= 1'b1;
    f_addr <= 24'h06_0010;
    d_req <= 1'b1;
    d_we <= 1'b0;
    d_addr <= 24'h80_3FFC;
    @(negedge i_clk);
    chk({f_rdy, d_rdy}, 32'h0000_0003);
    @(posedge i_clk);
    f_req <= 1'b0;
    d_req <= 1'b0;
    @(negedge i_clk);
    chk({f_val, d_val}, 32'h0000_0003);
    chk(f_data, 32'h1234_5678);
    op(0, 2, 24'hF0_FC00, 0);
    chk(got, 32'h0000_0001);
  end
  endtask
  task t_ahb;
  begin
    @(posedge i_clk);
    wait_cnt <= 2'h2;
    op(1, 2, 24'h40_0010, 32'hA5A5_0001);
    op(0, 2, 24'h40_0010, 0);
    chk(got, 32'hA5A5_0001);
    op(2, 2, 24'h80_0010, 0);
    chk(got, 32'hA5A5_0001);
    op(1, 0, 24'h40_0015, 32'h0000_7700);
    op(1, 1, 24'h40_0016, 32'h1234_0000);
  end
  endtask
  // First fault held, later faults ignored, a store to the error register re-arms
  task t_err;
  begin
    op(0, 2, 24'hE0_0020, 0);
    chk(m_err, 32'h0000_0001);
    op(1, 2, 24'hE0_0040, 0);
    op(0, 2, 24'hF0_FC04, 0);
    chk(got, 32'h00E0_0020);
    op(1, 0, 24'hF0_FC04, 0);
    op(0, 2, 24'hF0_FC04, 0);
    chk(got, 32'h0000_0000);
    op(0, 2, 24'hE0_0044, 0);
    op(0, 2, 24'hF0_FC04, 0);
    chk(got, 32'h00E0_0044);
  end
  endtask
  // Reset, then every scenario in turn
  initial
  begin
    mismatches = 0;
    checked = 0;
    i_rst = 1'b1;
    {f_req, d_req, d_we, d_size, wait_cnt, f_addr, d_addr, d_wdata} = 0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_sram;
    t_rom;
    t_alias;
    t_ahb;
    t_err;
    give_verdict;
  end
endmodule // tb
